// *** include/psi_defines.vh ***
`ifndef PSI_DEFINES_VH
`define PSI_DEFINES_VH
// ------------------------------------------------------------
// register addresses on the management bus (5-bit reg field)
// ------------------------------------------------------------
`define PSI_ADDR_STATUS 5'h01
`define PSI_ADDR_ID_HIGH 5'h02
`define PSI_ADDR_ID_LOW 5'h03
`define PSI_PHY_ADDR 5'h01
// ------------------------------------------------------------
// status register bit positions
// ------------------------------------------------------------
`define PSI_BIT_EXT_CAP 0
`define PSI_BIT_JABBER 1
`define PSI_BIT_LINK 2
`define PSI_BIT_AN_ABLE 3
`define PSI_BIT_RFAULT 4
`define PSI_BIT_AN_DONE 5
`define PSI_BIT_PRE_SUPP 6
`define PSI_RSVD_HI 10
`define PSI_RSVD_LO 7
`define PSI_CAP_HI 15
`define PSI_CAP_LO 11
// upper capability bits are outside this block; neutral default
`define PSI_CAP_VALUE 5'h0f
// ------------------------------------------------------------
// identity fields (values arbitrary, not a real vendor)
// ------------------------------------------------------------
`define PSI_ORG_ID 22'h0abcde
`define PSI_MODEL 6'h15
`define PSI_REVISION 4'h3
// ------------------------------------------------------------
// management frame layout
// ------------------------------------------------------------
`define PSI_PREAMBLE_LEN 6'd32
`define PSI_OP_READ 2'b10
`define PSI_OP_WRITE 2'b01
`define PSI_HDR_BITS 5'd14
`define PSI_DATA_BITS 5'd16
`endif

// *** core/psi_sync.v ***
// two-stage synchroniser for the pin-facing inputs
module psi_sync #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // data
   input wire [WIDTH-1:0] d_in,
   output reg [WIDTH-1:0] q_out
);
   reg [WIDTH-1:0] meta_reg;

   // first stage is read only by the second
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_reg <= {WIDTH{1'b0}};
         q_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= d_in;
         q_out <= meta_reg;
      end
   end
endmodule

// *** core/psi_status_latch.v ***
`include "psi_defines.vh"
// sticky status bits: set-high flags and the latch-low link bit
module psi_status_latch (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // conditions
   input wire remote_fault_far_end,
   input wire remote_fault_partner,
   input wire jabber_event,
   input wire speed_10,
   input wire link_up,
   // clear strobe from a status read
   input wire status_read,
   // latched values
   output reg rfault_reg,
   output reg jabber_reg,
   output reg link_reg
);
   wire rfault_set;
   assign rfault_set = remote_fault_far_end | remote_fault_partner;

   // set wins over the read clear, so an event at the read is not lost
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rfault_reg <= 1'b0;
         jabber_reg <= 1'b0;
         link_reg <= 1'b0;
      end else begin
         if (rfault_set)
            rfault_reg <= 1'b1;
         else if (status_read)
            rfault_reg <= 1'b0;
         // jabber only counts while running at 10 Mb/s
         if (jabber_event && speed_10)
            jabber_reg <= 1'b1;
         else if (status_read)
            jabber_reg <= 1'b0;
         // link drop wins; a read reloads the present link state
         if (!link_up)
            link_reg <= 1'b0;
         else if (status_read)
            link_reg <= 1'b1;
      end
   end
endmodule

// *** core/psi_mgmt_regs.v ***
`include "psi_defines.vh"
module psi_mgmt_regs #(
   parameter PHY_ADDR = `PSI_PHY_ADDR,
   parameter [21:0] ORG_ID = `PSI_ORG_ID,     // value arbitrary
   parameter [5:0] MODEL = `PSI_MODEL,        // value arbitrary
   parameter [3:0] REVISION = `PSI_REVISION   // bump per change
) (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // serial management pins
   input wire mdc,
   input wire mdio_in,
   output reg mdio_out,
   output reg mdio_oe_b,
   // phy state inputs
   input wire an_complete,
   input wire remote_fault_far_end,
   input wire remote_fault_partner,
   input wire jabber_event,
   input wire speed_10,
   input wire link_up
);
   // ------------------------------------------------------------
   // states and locals
   // ------------------------------------------------------------
   localparam ST_PRE = 3'd0;
   localparam ST_IDLE = 3'd1;
   localparam ST_HDR = 3'd2;
   localparam ST_TA = 3'd3;
   localparam ST_RDATA = 3'd4;
   localparam ST_WDATA = 3'd5;
   localparam ST_DONE = 3'd6;

   wire mdc_s;
   wire mdio_s;
   wire an_s;
   wire rf_far_s;
   wire rf_lp_s;
   wire jab_s;
   wire spd_s;
   wire link_s;
   wire rfault_q;
   wire jabber_q;
   wire link_q;

   reg mdc_d_reg;
   reg [2:0] state_reg;
   reg [5:0] pre_cnt_reg;
   reg pre_ok_reg;
   reg [4:0] bit_cnt_reg;
   reg [13:0] hdr_reg;
   reg [15:0] shift_reg;
   reg status_read_reg;
   reg ta_bad_reg;
   reg [15:0] rdata;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   // all pin-side signals pass two flops before any logic sees them
   psi_sync #(.WIDTH(8)) u_sync (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .d_in({mdc, mdio_in, an_complete, remote_fault_far_end,
             remote_fault_partner, jabber_event, speed_10, link_up}),
      .q_out({mdc_s, mdio_s, an_s, rf_far_s, rf_lp_s, jab_s, spd_s,
              link_s})
   );

   psi_status_latch u_latch (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .remote_fault_far_end(rf_far_s),
      .remote_fault_partner(rf_lp_s),
      .jabber_event(jab_s),
      .speed_10(spd_s),
      .link_up(link_s),
      .status_read(status_read_reg),
      .rfault_reg(rfault_q),
      .jabber_reg(jabber_q),
      .link_reg(link_q)
   );

   // ------------------------------------------------------------
   // read data mux
   // ------------------------------------------------------------
   wire mdc_rise = mdc_s & ~mdc_d_reg;
   wire mdc_fall = ~mdc_s & mdc_d_reg;
   wire [4:0] reg_addr = hdr_reg[4:0];
   wire [1:0] opcode = hdr_reg[11:10];
   wire addr_hit = (hdr_reg[9:5] == PHY_ADDR[4:0]);

   // identity words: org id bits 21..6 fill the high word, bits 5..0 lead the low word
   always @* begin
      rdata = 16'h0000;
      case (reg_addr)
         `PSI_ADDR_STATUS: begin
            rdata[`PSI_CAP_HI:`PSI_CAP_LO] = `PSI_CAP_VALUE;
            rdata[`PSI_RSVD_HI:`PSI_RSVD_LO] = 4'h0;
            rdata[`PSI_BIT_PRE_SUPP] = 1'b1;
            rdata[`PSI_BIT_AN_DONE] = an_s;
            rdata[`PSI_BIT_RFAULT] = rfault_q;
            rdata[`PSI_BIT_AN_ABLE] = 1'b1;
            rdata[`PSI_BIT_LINK] = link_q;
            rdata[`PSI_BIT_JABBER] = jabber_q;
            rdata[`PSI_BIT_EXT_CAP] = 1'b1;
         end
         `PSI_ADDR_ID_HIGH: rdata = ORG_ID[21:6];
         `PSI_ADDR_ID_LOW: rdata = {ORG_ID[5:0], MODEL, REVISION};
         default: rdata = 16'h0000;
      endcase
   end

   // ------------------------------------------------------------
   // management frame engine
   // ------------------------------------------------------------
   // bits are sampled on mdc rise; read data changes on mdc fall.
   // frames without preamble are taken once one full preamble has
   // been seen; a bad opcode or turnaround demands a new one.
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mdc_d_reg <= 1'b0;
         state_reg <= ST_PRE;
         pre_cnt_reg <= 6'd0;
         pre_ok_reg <= 1'b0;
         bit_cnt_reg <= 5'd0;
         hdr_reg <= 14'h0000;
         shift_reg <= 16'h0000;
         status_read_reg <= 1'b0;
         ta_bad_reg <= 1'b0;
         mdio_out <= 1'b1;
         mdio_oe_b <= 1'b1;
      end else begin
         mdc_d_reg <= mdc_s;
         status_read_reg <= 1'b0;
         case (state_reg)
            ST_PRE: begin
               // count ones; a zero after 32 ones is the start bit.
               // once a preamble was seen, idle ones are skipped and
               // any zero starts a frame, so idle highs never fake one
               if (mdc_rise) begin
                  if (mdio_s) begin
                     if (pre_cnt_reg != `PSI_PREAMBLE_LEN)
                        pre_cnt_reg <= pre_cnt_reg + 6'd1;
                  end else if (pre_ok_reg ||
                     pre_cnt_reg == `PSI_PREAMBLE_LEN) begin
                     pre_ok_reg <= 1'b1;
                     state_reg <= ST_IDLE;
                     bit_cnt_reg <= 5'd0;
                  end else begin
                     pre_cnt_reg <= 6'd0;
                  end
               end
            end
            ST_IDLE: begin
               // second start bit (1) begins the header
               if (mdc_rise && mdio_s) begin
                  state_reg <= ST_HDR;
                  bit_cnt_reg <= 5'd0;
               end
            end
            ST_HDR: begin
               if (mdc_rise) begin
                  hdr_reg <= {hdr_reg[12:0], mdio_s};
                  bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  if (bit_cnt_reg == `PSI_HDR_BITS - 5'd3) begin
                     state_reg <= ST_TA;
                     bit_cnt_reg <= 5'd0;
                  end
               end
            end
            ST_TA: begin
               // header now holds op(2) phy(5) reg(5) and fits 12 bits
               if (opcode != `PSI_OP_READ && opcode != `PSI_OP_WRITE) begin
                  pre_ok_reg <= 1'b0;
                  pre_cnt_reg <= 6'd0;
                  state_reg <= ST_PRE;
               end else if (opcode == `PSI_OP_READ) begin
                  if (addr_hit && mdc_fall) begin
                     // release on first ta bit, drive zero on second
                     if (bit_cnt_reg == 5'd1) begin
                        mdio_oe_b <= 1'b0;
                        mdio_out <= 1'b0;
                        shift_reg <= rdata;
                        // only a status read clears the latches
                        status_read_reg <= (reg_addr == `PSI_ADDR_STATUS);
                        state_reg <= ST_RDATA;
                        bit_cnt_reg <= 5'd0;
                     end else begin
                        bit_cnt_reg <= bit_cnt_reg + 5'd1;
                     end
                  end else if (!addr_hit && mdc_rise) begin
                     bit_cnt_reg <= bit_cnt_reg + 5'd1;
                     if (bit_cnt_reg == 5'd1) begin
                        state_reg <= ST_RDATA;
                        bit_cnt_reg <= 5'd0;
                     end
                  end
               end else if (mdc_rise) begin
                  // write turnaround must be 1 then 0
                  if (bit_cnt_reg == 5'd0)
                     ta_bad_reg <= ~mdio_s;
                  bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  if (bit_cnt_reg == 5'd1) begin
                     if (ta_bad_reg || mdio_s) begin
                        pre_ok_reg <= 1'b0;
                        pre_cnt_reg <= 6'd0;
                        state_reg <= ST_PRE;
                     end else begin
                        state_reg <= ST_WDATA;
                     end
                     bit_cnt_reg <= 5'd0;
                  end
               end
            end
            ST_RDATA: begin
               // shift out msb first; foreign frames are just timed
               if (addr_hit && mdc_fall) begin
                  mdio_out <= shift_reg[15];
                  shift_reg <= {shift_reg[14:0], 1'b0};
                  bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  if (bit_cnt_reg == `PSI_DATA_BITS) begin
                     mdio_oe_b <= 1'b1;
                     mdio_out <= 1'b1;
                     state_reg <= ST_DONE;
                  end
               end else if (!addr_hit && mdc_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  if (bit_cnt_reg == `PSI_DATA_BITS - 5'd1)
                     state_reg <= ST_DONE;
               end
            end
            ST_WDATA: begin
               // write data is consumed and dropped: all read-only
               if (mdc_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  if (bit_cnt_reg == `PSI_DATA_BITS - 5'd1)
                     state_reg <= ST_DONE;
               end
            end
            ST_DONE: begin
               // back to ST_PRE at once to wait for the next start zero; a one there is idle
               state_reg <= ST_PRE;
               bit_cnt_reg <= 5'd0;
            end
            default: begin
               state_reg <= ST_PRE;
            end
         endcase
      end
   end
endmodule

// *** sim/psi_mgmt_regs_properties.sv ***
// ---------------------------------------------
// pin checker for the management engine
// ---------------------------------------------
module psi_mgmt_regs_properties (
   // clock and reset
   input wire core_clk,
   input wire rst_b,
   // management pins
   input wire mdc,
   input wire mdio_out,
   input wire mdio_oe_b
);
   reg mdc_q;
   reg oe_q;
   reg seen_drive;
   reg [7:0] rise_cnt;
   reg [4:0] fall_cnt;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   // raw pin edge counts; rises restart after each answer ends
   always @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mdc_q <= 1'b1;
         oe_q <= 1'b1;
         seen_drive <= 1'b0;
         rise_cnt <= 8'h00;
         fall_cnt <= 5'h00;
      end else begin
         mdc_q <= mdc;
         oe_q <= mdio_oe_b;
         if (!mdio_oe_b)
            seen_drive <= 1'b1;
         if (mdio_oe_b && !oe_q)
            rise_cnt <= 8'h00;
         else if (mdc && !mdc_q && rise_cnt != 8'hff)
            rise_cnt <= rise_cnt + 8'h01; // saturates, no wrap
         if (mdio_oe_b)
            fall_cnt <= 5'h00;
         else if (!mdc && mdc_q)
            fall_cnt <= fall_cnt + 5'h01;
      end
   end
   reset_idle_a:
   assert property ($rose(rst_b) |-> mdio_oe_b && mdio_out)
      else $error("pins not idle after reset");
   first_preamble_a:
   assert property ($fell(mdio_oe_b) && !seen_drive |-> rise_cnt >= 8'h2f)
      else $error("answer without full preamble");
   header_len_a:
   assert property ($fell(mdio_oe_b) |-> rise_cnt >= 8'h0f)
      else $error("answer before header complete");
   ta_zero_a:
   assert property ($fell(mdio_oe_b) |-> !mdio_out)
      else $error("turnaround bit not zero");
   word_len_a:
   assert property ($rose(mdio_oe_b) |-> fall_cnt == 5'h11)
      else $error("answer length wrong");
   drive_hold_a:
   assert property ($fell(mdio_oe_b) |=> !mdio_oe_b [*8])
      else $error("drive dropped early");
   bit_on_fall_a:
   assert property (!mdio_oe_b && $changed(mdio_out) |-> !mdc)
      else $error("data changed with clock high");
   idle_high_a:
   assert property (mdio_oe_b [*3] |-> mdio_out)
      else $error("idle data not high");
   cover property ($fell(mdio_oe_b));
   cover property ($rose(mdio_oe_b));
   cover property (rise_cnt == 8'hff);
endmodule

bind psi_mgmt_regs psi_mgmt_regs_properties chk (.core_clk(core_clk),
   .rst_b(rst_b), .mdc(mdc), .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b));

// *** sim/psi_smi_master.sv ***
// station manager: slow clock, stands high between frames
module psi_smi_master (
   // system clock
   input wire core_clk,
   // resolved data line
   input wire mdio_w,
   // driven lines
   output reg mdc,
   output reg mst_bit,
   output reg mst_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   localparam HALF = 10;
   // idle levels at time zero
   initial begin
      mdc = 1'b1;
      mst_bit = 1'b1;
      mst_oe = 1'b0;
   end
   // one bit period: data changes on the fall, sampled before the rise
   task cyc(input b, input drv, output s);
      begin
         mdc <= 1'b0;
         mst_bit <= b;
         mst_oe <= drv;
         repeat (HALF) @(posedge core_clk);
         s = mdio_w;
         mdc <= 1'b1;
         repeat (HALF) @(posedge core_clk);
      end
   endtask
   // whole frame; line released for turnaround and data unless writing
   task frame(input pre, input [1:0] op, input [4:0] phy, input [4:0] rg,
      input [15:0] wd, output [15:0] rd);
      reg s;
      reg [13:0] hdr;
      reg [17:0] tail;
      integer i;
      begin
         hdr = {2'b01, op, phy, rg};
         tail = {2'b10, wd};
         rd = 16'h0000;
         if (pre)
            for (i = 0; i < 32; i = i + 1) cyc(1'b1, 1'b1, s);
         for (i = 13; i >= 0; i = i - 1) cyc(hdr[i], 1'b1, s);
         for (i = 17; i >= 0; i = i - 1) begin
            cyc(tail[i], op == 2'b01, s);
            rd = {rd[14:0], s};
         end
         cyc(1'b1, 1'b0, s); // last fall lets the device release
      end
   endtask
endmodule

// *** sim/psi_mgmt_regs_test.sv ***
`include "psi_defines.vh"
module psi_mgmt_regs_test;
   timeunit 1ns;
   timeprecision 100ps;
   localparam [21:0] ORG = `PSI_ORG_ID;
   localparam [4:0] ST = `PSI_ADDR_STATUS;
   localparam [4:0] IDH = `PSI_ADDR_ID_HIGH;
   localparam [4:0] IDL = `PSI_ADDR_ID_LOW;
   reg core_clk = 1'b0;
   reg rst_b = 1'b0;
   reg an_complete = 1'b0;
   reg remote_fault_far_end = 1'b0;
   reg remote_fault_partner = 1'b0;
   reg jabber_event = 1'b0;
   reg speed_10 = 1'b0;
   reg link_up = 1'b1;
   reg [15:0] rd;
   integer errors = 0;
   integer comparisons = 0;
   integer cycles = 0;
   wire mdc, mst_bit, mst_oe, mdio_out, mdio_oe_b;
   // pulled-up line: device, then manager, then pull-up
   wire mdio_w = !mdio_oe_b ? mdio_out : (mst_oe ? mst_bit : 1'b1);
   always #5 core_clk = ~core_clk;
   psi_smi_master mst (.core_clk(core_clk), .mdio_w(mdio_w), .mdc(mdc),
      .mst_bit(mst_bit), .mst_oe(mst_oe));
   psi_mgmt_regs uut (.core_clk(core_clk), .rst_b(rst_b), .mdc(mdc),
      .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe_b(mdio_oe_b),
      .an_complete(an_complete), .remote_fault_far_end(remote_fault_far_end),
      .remote_fault_partner(remote_fault_partner),
      .jabber_event(jabber_event), .speed_10(speed_10), .link_up(link_up));
   task print_verdict;
      begin
         if (errors == 0 && comparisons > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // hang guard, well above the ~18k cycles of the sequence
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 80000) begin
         errors = errors + 1;
         print_verdict;
      end
   end
   task cmp(input [15:0] got, input [15:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            errors = errors + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   function [15:0] st(input an, input rf, input lk, input jb);
      st = {`PSI_CAP_VALUE, 4'h0, 1'b1, an, rf, 1'b1, lk, jb, 1'b1};
   endfunction
   task rdv(input pre, input [4:0] phy, input [4:0] rg);
      mst.frame(pre, `PSI_OP_READ, phy, rg, 16'h0000, rd);
   endtask
   task wr(input [4:0] rg, input [15:0] d);
      mst.frame(1'b0, `PSI_OP_WRITE, `PSI_PHY_ADDR, rg, d, rd);
   endtask
   task w5;
      repeat (5) @(posedge core_clk);
   endtask
   // ---------------------------------------------
   // scenarios
   // ---------------------------------------------
   task t_ident;
      begin
         rdv(0, `PSI_PHY_ADDR, IDH); cmp(rd, 16'hffff);
         rdv(1, `PSI_PHY_ADDR, IDH); cmp(rd, ORG[21:6]);
         rdv(0, `PSI_PHY_ADDR, IDL); // next line checks the low word
         cmp(rd, {ORG[5:0], `PSI_MODEL, `PSI_REVISION});
         wr(IDH, 16'h0000);
         wr(IDL, 16'hffff);
         rdv(0, `PSI_PHY_ADDR, IDH); cmp(rd, ORG[21:6]);
         rdv(0, `PSI_PHY_ADDR, IDL); // low word after the write
         cmp(rd, {ORG[5:0], `PSI_MODEL, `PSI_REVISION});
         rdv(0, 5'h1e, IDH); cmp(rd, 16'hffff);
      end
   endtask
   task t_status;
      begin
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 0, 0));
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 0));
         an_complete <= 1'b1;
         w5;
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(1, 0, 1, 0));
         an_complete <= 1'b0;
         w5;
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 0));
      end
   endtask
   task t_sticky;
      begin
         remote_fault_far_end <= 1'b1;
         w5;
         remote_fault_far_end <= 1'b0;
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 1, 1, 0));
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 0));
         remote_fault_partner <= 1'b1;
         w5;
         remote_fault_partner <= 1'b0;
         rdv(0, `PSI_PHY_ADDR, IDH); // id read must not clear the flag
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 1, 1, 0));
         jabber_event <= 1'b1;
         w5;
         jabber_event <= 1'b0;
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 0));
         speed_10 <= 1'b1;
         jabber_event <= 1'b1;
         w5;
         jabber_event <= 1'b0;
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 1));
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 0));
         speed_10 <= 1'b0;
      end
   endtask
   task t_link;
      begin
         link_up <= 1'b0;
         w5;
         link_up <= 1'b1;
         w5;
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 0, 0));
         wr(ST, 16'hffff);
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 0));
      end
   endtask
   task t_badop;
      begin
         mst.frame(1'b0, 2'b11, `PSI_PHY_ADDR, ST, 16'h0000, rd);
         rdv(0, `PSI_PHY_ADDR, ST); cmp(rd, 16'hffff);
         rdv(1, `PSI_PHY_ADDR, ST); cmp(rd, st(0, 0, 1, 0));
      end
   endtask
   // main sequence
   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      t_ident;
      t_status;
      t_sticky;
      t_link;
      t_badop;
      print_verdict;
   end
endmodule
